// file: core/eeprom_host_pkg.sv
// Constants, timing counts and command encodings for the paged EEPROM host controller
package eeprom_host_pkg;
   localparam int CLK_NS = 100;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CMD_ADDR_W = 15;
   localparam int PAGE_LSB = 8;
   localparam int PAGE_W = ADDR_W - PAGE_LSB;
   localparam int PAGE_BYTES = 256;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int SEQ_LEN = 3;
   // Pin timing, least times round up
   localparam int WP_NS = 100;
   localparam int WPH_NS = 50;
   localparam int ACC_NS = 200;
   localparam int OEHP_NS = 150;
   localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int OEHP_CYC = (OEHP_NS + CLK_NS - 1) / CLK_NS;
   // Longest gap between byte loads rounds down; margin covers setup before the falling strobe
   localparam int BLC_US = 150;
   localparam int BLC_CYC = (BLC_US * 1000) / CLK_NS;
   localparam int GAP_MARGIN = 8;
   localparam int GAP_LIMIT = BLC_CYC - GAP_MARGIN;
   localparam int WC_MS = 10;
   localparam int WC_CYC = (WC_MS * 1000000) / CLK_NS;
   localparam int WC_W = 24;
   typedef enum logic [1:0]
   {
      CMD_READ = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_LOCK_ON = 2'h2,
      CMD_LOCK_OFF = 2'h3
   } cmd_type;
   localparam logic [CMD_ADDR_W-1:0] SEQ_ADDR_0 = 15'h5555;
   localparam logic [CMD_ADDR_W-1:0] SEQ_ADDR_1 = 15'h2aaa;
   localparam logic [CMD_ADDR_W-1:0] SEQ_ADDR_2 = 15'h5555;
   localparam logic [DATA_W-1:0] SEQ_DATA_0 = 8'haa;
   localparam logic [DATA_W-1:0] SEQ_DATA_1 = 8'h55;
   localparam logic [DATA_W-1:0] SEQ_LOCK_ON_2 = 8'ha0;
   localparam logic [DATA_W-1:0] SEQ_LOCK_OFF_2 = 8'h80;
endpackage

// file: core/bus_cycle_if.sv
// Single bus cycle request and answer between sequencer and pin engine
`timescale 1ns/1ns
interface bus_cycle_if;
   logic req;
   logic wr;
   logic [18:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport master (output req, output wr, output addr, output wdata, input done, input rdata);
   modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// file: core/pin_cycle_engine.sv
// Pin level read and write strobe generator for the parallel EEPROM bus
`timescale 1ns/1ns
module pin_cycle_engine
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   bus_cycle_if.engine cyc,
   output logic [18:0] o_addr,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [7:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [7:0] i_dq_in
);
   typedef enum logic [2:0]
   {
      E_IDLE = 3'h0,
      E_SETUP = 3'h1,
      E_STROBE = 3'h3,
      E_HOLD = 3'h2,
      E_DONE = 3'h6,
      E_READ = 3'h4,
      E_GAP = 3'h5
   } eng_type;
   eng_type state_q;
   logic [1:0] cnt_q;
   logic done_q;
   logic [7:0] rdata_q;

   assign cyc.done = done_q;
   assign cyc.rdata = rdata_q;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= E_IDLE;
         cnt_q <= 2'h0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         cnt_q <= cnt_q + 2'h1;
         case (state_q)
            E_IDLE:
            begin
               cnt_q <= 2'h0;
               if (cyc.req)
                  state_q <= cyc.wr ? E_SETUP : E_READ;
            end
            E_SETUP:
            begin
               cnt_q <= 2'h0;
               state_q <= E_STROBE;
            end
            E_STROBE:
               if (cnt_q == 2'(eeprom_host_pkg::WP_CYC - 1))
               begin
                  cnt_q <= 2'h0;
                  state_q <= E_HOLD;
               end
            E_HOLD:
               if (cnt_q == 2'(eeprom_host_pkg::WPH_CYC - 1))
               begin
                  done_q <= 1'b1;
                  state_q <= E_DONE;
               end
            E_READ:
               if (cnt_q == 2'(eeprom_host_pkg::ACC_CYC - 1))
               begin
                  cnt_q <= 2'h0;
                  state_q <= E_GAP;
               end
            E_GAP:
               // Keeps output enable high long enough between polling reads
               if (cnt_q == 2'(eeprom_host_pkg::OEHP_CYC - 1))
               begin
                  done_q <= 1'b1;
                  state_q <= E_DONE;
               end
            default:
               state_q <= E_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_addr <= 19'h0;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_dq_out <= 8'h00;
         o_dq_oe <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         case (state_q)
            E_IDLE:
               if (cyc.req)
               begin
                  o_addr <= cyc.addr;
                  o_ce_n <= 1'b0;
                  o_oe_n <= cyc.wr; // RULE_07
                  o_dq_out <= cyc.wdata;
                  o_dq_oe <= cyc.wr;
               end
            E_SETUP:
               o_we_n <= 1'b0;
            E_STROBE:
               if (cnt_q == 2'(eeprom_host_pkg::WP_CYC - 1))
                  o_we_n <= 1'b1;
            E_HOLD:
               if (cnt_q == 2'(eeprom_host_pkg::WPH_CYC - 1))
               begin
                  o_ce_n <= 1'b1;
                  o_dq_oe <= 1'b0;
               end
            E_READ:
               if (cnt_q == 2'(eeprom_host_pkg::ACC_CYC - 1))
               begin
                  rdata_q <= i_dq_in; // RULE_10
                  o_oe_n <= 1'b1;
                  o_ce_n <= 1'b1;
               end
            default:
            begin
               o_we_n <= 1'b1;
            end
         endcase
      end
   end

   sequence s_strobe_low;
      !o_we_n && !o_ce_n && o_oe_n && o_dq_oe;
   endsequence
   sequence s_strobe_end;
      o_we_n ##1 o_ce_n && !o_dq_oe;
   endsequence

   a_oe_during_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!o_we_n && !o_ce_n) |-> o_oe_n) else $error("Output enable low during a byte load"); // RULE_07
   a_strobe_shape: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $fell(o_we_n) |-> s_strobe_low ##1 s_strobe_end) else $error("Write strobe shape wrong"); // RULE_03
   a_read_access: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $fell(o_oe_n) |-> (!o_oe_n && !o_ce_n && o_we_n && !o_dq_oe) [*2] ##1 o_oe_n)
      else $error("Read access window wrong"); // RULE_10
endmodule

// file: core/eeprom_page_host.sv
// Host controller for a paged parallel EEPROM with software write lock and end-of-write polling
// Operation
// RULE_01 - Every byte of one page load keeps the same page address on A8 to A18 at each falling write strobe.
// RULE_02 - A lock command sequence drives the fixed command address on the low fifteen lines for its first 3 writes.
// RULE_03 - Command bytes sit on I/O7 to I/O0 and command addresses are decoded from A14 to A0 only.
// RULE_04 - After the lock-on sequence the device becomes write protected when the next write period ends.
// RULE_05 - After the lock-off sequence the device leaves write protection when the next write period ends.
// RULE_06 - After a lock prefix one to 256 data bytes may follow and form one page write.
// RULE_07 - Output enable stays high whenever write enable and chip enable are both low.
// RULE_08 - Each next byte write starts no later than 150 us after the previous one to keep the page open.
// RULE_09 - A longer gap ends the page load and the device starts programming the latched bytes.
// RULE_10 - With chip and output enable low and write enable high the device drives the stored byte.
// RULE_11 - During the write period a read of the last byte returns its top bit inverted.
// RULE_12 - During the write period I/O6 toggles on each read and stops once the write completes.
// RULE_13 - The self-timed write finishes within 10 ms, after which normal access resumes.
`timescale 1ns/1ns
module eeprom_page_host
#(
   parameter int WC_CYCLES = eeprom_host_pkg::WC_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic [1:0] i_cmd,
   input wire logic [18:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_last,
   input wire logic i_locked,
   output logic o_ready,
   output logic o_accept,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_write_done,
   output logic o_timeout,
   output logic [18:0] o_addr,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [7:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [7:0] i_dq_in
);
   typedef enum logic [2:0]
   {
      M_IDLE = 3'h0,
      M_PRE = 3'h1,
      M_DATA = 3'h3,
      M_OPEN = 3'h2,
      M_POLL = 3'h6,
      M_READ = 3'h4
   } main_type;

   function automatic logic [10:0] page_of(input logic [18:0] a);
      page_of = a[18:eeprom_host_pkg::PAGE_LSB];
   endfunction

   function automatic logic [14:0] seq_addr(input logic [1:0] idx);
      seq_addr = (idx == 2'h0) ? eeprom_host_pkg::SEQ_ADDR_0 :
                 (idx == 2'h1) ? eeprom_host_pkg::SEQ_ADDR_1 : eeprom_host_pkg::SEQ_ADDR_2;
   endfunction

   function automatic logic [7:0] seq_data(input logic [1:0] idx, input logic off);
      seq_data = (idx == 2'h0) ? eeprom_host_pkg::SEQ_DATA_0 :
                 (idx == 2'h1) ? eeprom_host_pkg::SEQ_DATA_1 :
                 off ? eeprom_host_pkg::SEQ_LOCK_OFF_2 : eeprom_host_pkg::SEQ_LOCK_ON_2;
   endfunction

   bus_cycle_if cyc ();

   main_type state_q;
   logic [1:0] op_q;
   logic [1:0] idx_q;
   logic [18:0] wa_q;
   logic [7:0] wd_q;
   logic last_q;
   logic [10:0] page_q;
   logic [8:0] bytes_q;
   logic [10:0] gap_q;
   logic [23:0] wc_q;
   logic [18:0] poll_addr_q;
   logic chk7_q;
   logic bit7_q;
   logic prev6_q;
   logic havep_q;
   logic req_q;
   logic wr_q;
   logic [18:0] caddr_q;
   logic [7:0] cdata_q;
   logic cyc_wr_d;
   logic [18:0] cyc_addr_d;
   logic [7:0] cyc_data_d;
   logic take_idle;
   logic take_open;
   logic poll_done;
   logic wc_over;

   assign cyc.req = req_q;
   assign cyc.wr = wr_q;
   assign cyc.addr = caddr_q;
   assign cyc.wdata = cdata_q;

   assign take_idle = (state_q == M_IDLE) && i_req && o_ready;
   // Only same-page writes extend an open load; anything else closes the page first
   assign take_open = (state_q == M_OPEN) && i_req && o_ready && (i_cmd == eeprom_host_pkg::CMD_WRITE)
                      && (page_of(i_addr) == page_q) && (bytes_q < 9'(eeprom_host_pkg::PAGE_BYTES)); // RULE_01
   // Write ends when I/O6 stops toggling and, for data, the top bit matches the written byte
   assign poll_done = havep_q && (cyc.rdata[eeprom_host_pkg::TOGGLE_BIT] == prev6_q)
                      && (!chk7_q || (cyc.rdata[eeprom_host_pkg::POLL_BIT] == bit7_q)); // RULE_11 RULE_12
   assign wc_over = wc_q >= 24'(WC_CYCLES - 1); // RULE_13

   always_comb
   begin
      cyc_wr_d = 1'b1;
      cyc_addr_d = wa_q;
      cyc_data_d = wd_q;
      case (state_q)
         M_PRE:
         begin
            cyc_addr_d = {4'h0, seq_addr(idx_q)}; // RULE_02 RULE_03
            cyc_data_d = seq_data(idx_q, op_q == eeprom_host_pkg::CMD_LOCK_OFF); // RULE_03
         end
         M_POLL:
         begin
            cyc_wr_d = 1'b0;
            cyc_addr_d = poll_addr_q;
         end
         M_READ:
            cyc_wr_d = 1'b0;
         default:
            cyc_wr_d = 1'b1;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= M_IDLE;
         op_q <= 2'h0;
         idx_q <= 2'h0;
         wa_q <= 19'h0;
         wd_q <= 8'h00;
         last_q <= 1'b0;
         page_q <= 11'h0;
         bytes_q <= 9'h0;
         poll_addr_q <= 19'h0;
         chk7_q <= 1'b0;
         bit7_q <= 1'b0;
         prev6_q <= 1'b0;
         havep_q <= 1'b0;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         caddr_q <= 19'h0;
         cdata_q <= 8'h00;
      end
      else
      begin
         if (state_q != M_IDLE && state_q != M_OPEN && !req_q && !cyc.done)
         begin
            req_q <= 1'b1;
            wr_q <= cyc_wr_d;
            caddr_q <= cyc_addr_d;
            cdata_q <= cyc_data_d;
         end
         if (cyc.done)
            req_q <= 1'b0;
         case (state_q)
            M_IDLE:
               if (take_idle)
               begin
                  op_q <= i_cmd;
                  wa_q <= i_addr;
                  wd_q <= i_wdata;
                  last_q <= i_last;
                  page_q <= page_of(i_addr);
                  bytes_q <= 9'h0;
                  idx_q <= 2'h0;
                  havep_q <= 1'b0;
                  if (i_cmd == eeprom_host_pkg::CMD_READ)
                     state_q <= M_READ;
                  else if (i_cmd == eeprom_host_pkg::CMD_WRITE && !i_locked)
                     state_q <= M_DATA;
                  else
                     state_q <= M_PRE;
               end
            M_PRE:
               if (cyc.done)
               begin
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'(eeprom_host_pkg::SEQ_LEN - 1))
                  begin
                     if (op_q == eeprom_host_pkg::CMD_WRITE)
                        state_q <= M_DATA;
                     else
                     begin
                        // Bare lock command still runs a write period before taking effect
                        poll_addr_q <= caddr_q; // RULE_04 RULE_05
                        chk7_q <= 1'b0;
                        state_q <= M_POLL;
                     end
                  end
               end
            M_DATA:
               if (cyc.done)
               begin
                  bytes_q <= bytes_q + 9'h1;
                  poll_addr_q <= wa_q;
                  bit7_q <= wd_q[eeprom_host_pkg::POLL_BIT];
                  chk7_q <= 1'b1;
                  if (last_q || bytes_q == 9'(eeprom_host_pkg::PAGE_BYTES - 1)) // RULE_06
                     state_q <= M_POLL;
                  else
                     state_q <= M_OPEN;
               end
            M_OPEN:
               if (take_open)
               begin
                  wa_q <= i_addr;
                  wd_q <= i_wdata;
                  last_q <= i_last;
                  state_q <= M_DATA; // RULE_08
               end
               else if (i_req && o_ready || gap_q >= 11'(eeprom_host_pkg::GAP_LIMIT))
                  state_q <= M_POLL; // RULE_09
            M_POLL:
               if (cyc.done)
               begin
                  prev6_q <= cyc.rdata[eeprom_host_pkg::TOGGLE_BIT];
                  havep_q <= 1'b1;
                  if (poll_done || wc_over)
                     state_q <= M_IDLE;
               end
            M_READ:
               if (cyc.done)
                  state_q <= M_IDLE;
            default:
               state_q <= M_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         gap_q <= 11'h0;
         wc_q <= 24'h0;
      end
      else
      begin
         gap_q <= (state_q == M_OPEN) ? gap_q + 11'h1 : 11'h0; // RULE_08
         wc_q <= (state_q == M_POLL) ? wc_q + 24'h1 : 24'h0; // RULE_13
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ready <= 1'b0;
         o_accept <= 1'b0;
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
         o_write_done <= 1'b0;
         o_timeout <= 1'b0;
      end
      else
      begin
         o_ready <= (state_q == M_IDLE && !take_idle) || (state_q == M_OPEN && !i_req);
         o_accept <= take_idle || take_open;
         o_rvalid <= (state_q == M_READ) && cyc.done;
         if ((state_q == M_READ) && cyc.done)
            o_rdata <= cyc.rdata;
         o_write_done <= (state_q == M_POLL) && cyc.done && (poll_done || wc_over);
         // A new timeout wins over the clear by the next accepted write
         if (take_idle && i_cmd != eeprom_host_pkg::CMD_READ)
            o_timeout <= 1'b0;
         if ((state_q == M_POLL) && cyc.done && wc_over && !poll_done)
            o_timeout <= 1'b1; // RULE_13
      end
   end

   pin_cycle_engine u_engine
   (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .cyc(cyc.engine),
      .o_addr(o_addr),
      .o_ce_n(o_ce_n),
      .o_oe_n(o_oe_n),
      .o_we_n(o_we_n),
      .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe),
      .i_dq_in(i_dq_in)
   );

   sequence s_page_write_req;
      req_q && wr_q && state_q == M_DATA && bytes_q != 9'h0;
   endsequence

   a_page_addr_same: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_page_write_req |-> page_of(caddr_q) == page_q) else $error("Page address changed in a load"); // RULE_01
   a_prefix_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (req_q && state_q == M_PRE) |-> caddr_q[14:0] == seq_addr(idx_q) && wr_q)
      else $error("Command address out of order"); // RULE_02
   a_page_count: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      bytes_q <= 9'(eeprom_host_pkg::PAGE_BYTES)) else $error("Page load exceeds 256 bytes"); // RULE_06
   a_gap_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_q == M_OPEN && gap_q >= 11'(eeprom_host_pkg::GAP_LIMIT)) |=> state_q != M_OPEN)
      else $error("Page held open past load window"); // RULE_09
   // Gap counter bounds the open window; a delay range this long would be too costly to unroll
   a_next_byte_time: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
      (state_q == M_OPEN) |-> gap_q <= 11'(eeprom_host_pkg::GAP_LIMIT))
      else $error("Load gap too long");
   a_lock_then_poll: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_q == M_PRE && cyc.done && idx_q == 2'h2 && op_q[1]) |=> state_q == M_POLL && !chk7_q)
      else $error("Lock command not followed by write period"); // RULE_04 RULE_05
   a_poll_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_q == M_POLL) |-> wc_q <= 24'(WC_CYCLES + 8)) else $error("Write period wait unbounded"); // RULE_13
   a_rvalid_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_rvalid |-> $past(state_q == M_READ) && o_rdata == $past(cyc.rdata)) else $error("Read data pulse wrong"); // RULE_10
endmodule

// file: tb/eeprom_device_model.sv
// Behavioural paged EEPROM device that answers the host controller pins
`timescale 1ns/1ns
module eeprom_device_model
(
   input wire logic i_mclk,
   input wire logic [18:0] i_addr,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [7:0] i_dq,
   input wire logic [31:0] i_wc,
   output logic [7:0] o_dq
);
   localparam int LOAD_WINDOW = 1500;
   localparam logic [7:0] BLANK = 8'hff;
   logic [7:0] mem [0:524287];
   logic [7:0] pg_data [$];
   int pg_addr [$];
   int step = 0;
   int load_cnt = -1;
   int busy_cnt = 0;
   logic locked = 1'b0;
   logic lock_next = 1'b0;
   logic prefixed = 1'b0;
   logic tog = 1'b0;
   logic we_q = 1'b1;
   logic oe_q = 1'b1;
   logic [7:0] last_d = 8'h00;
   logic [7:0] last_out = 8'h00;
   logic [7:0] out_val;
   wire reading = !i_ce_n && !i_oe_n && i_we_n;
   initial
      foreach (mem[i])
         mem[i] = BLANK;
   // Load window counts as busy, so a poll never sees stale true data
   assign out_val = (load_cnt >= 0 || busy_cnt > 0) ? {~last_d[7], tog, last_d[5:0]} : mem[i_addr];
   // A released bus shows the inverse of the last value, never a held copy
   assign o_dq = reading ? out_val : ~last_out;
   task automatic load_byte(input logic [18:0] a, input logic [7:0] d);
      last_d = d;
      load_cnt = 0;
      if (step == 0 && a[14:0] == 15'h5555 && d == 8'haa)
         step = 1;
      else if (step == 1 && a[14:0] == 15'h2aaa && d == 8'h55)
         step = 2;
      else if (step == 2 && a[14:0] == 15'h5555 && (d == 8'ha0 || d == 8'h80))
      begin
         step = 3;
         prefixed = 1'b1;
         lock_next = d == 8'ha0;
      end
      else if (!locked || prefixed)
      begin
         pg_addr.push_back(int'(a));
         pg_data.push_back(d);
      end
   endtask
   task automatic finish_write();
      foreach (pg_addr[i])
         mem[pg_addr[i]] = pg_data[i];
      if (prefixed)
         locked = lock_next;
      prefixed = 1'b0;
      step = 0;
      pg_addr.delete();
      pg_data.delete();
   endtask
   always @(posedge i_mclk)
   begin
      if (load_cnt >= 0)
         load_cnt++;
      if (!we_q && i_we_n && !i_ce_n && i_oe_n && busy_cnt == 0)
         load_byte(i_addr, i_dq);
      else if (load_cnt > LOAD_WINDOW)
      begin
         load_cnt = -1;
         busy_cnt = i_wc;
      end
      else if (busy_cnt > 0)
      begin
         busy_cnt--;
         if (busy_cnt == 0)
            finish_write();
      end
      if (reading && oe_q)
         tog = !tog;
      if (reading)
         last_out = out_val;
      we_q = i_we_n;
      oe_q = i_oe_n;
   end
endmodule

// file: tb/eeprom_page_host_bench.sv
// Self-checking bench for the paged EEPROM host controller
`timescale 1ns/1ns
module eeprom_page_host_bench;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_req = 1'b0;
   logic [1:0] i_cmd = 2'h0;
   logic [18:0] i_addr = 19'h0_0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_last = 1'b0;
   logic i_locked = 1'b0;
   logic o_ready, o_accept, o_rvalid, o_write_done, o_timeout, o_ce_n, o_oe_n, o_we_n, o_dq_oe;
   logic [7:0] o_rdata, o_dq_out, dev_dq, dq_bus, rd;
   logic [18:0] o_addr;
   logic [31:0] wc = 32'h0000_012c;
   logic [26:0] wr_log [$];
   logic [7:0] ref_mem [int];
   int fails = 0;
   int check_count = 0;
   int dones = 0;
   assign dq_bus = o_dq_oe ? o_dq_out : dev_dq;
   always #50 i_mclk = ~i_mclk;
   // Short write period limit keeps the timeout case quick
   eeprom_page_host #(.WC_CYCLES(4000)) i_eeprom_page_host (.*, .i_dq_in(dq_bus));
   eeprom_device_model i_eeprom_device_model (.i_mclk(i_mclk), .i_addr(o_addr), .i_ce_n(o_ce_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(dq_bus), .i_wc(wc), .o_dq(dev_dq));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge i_mclk)
      if (o_write_done === 1'b1)
         dones++;
   always @(posedge o_we_n)
      if (o_ce_n === 1'b0)
         wr_log.push_back({o_addr, dq_bus});
   always @(negedge i_mclk)
      if (o_ce_n === 1'b0 && o_we_n === 1'b0)
         check(o_oe_n, 1'b1);
   task automatic tick();
      @(posedge i_mclk);
      #1;
   endtask
   task automatic wait_done(input int d0);
      for (int n = 0; n < 20000 && dones == d0; n++)
         tick();
   endtask
   task automatic req(input logic [1:0] c, input logic [18:0] a, input logic [7:0] d, input logic l, input logic k);
      for (int n = 0; n < 9000 && o_ready !== 1'b1; n++)
         tick();
      i_req = 1'b1;
      i_cmd = c;
      i_addr = a;
      i_wdata = d;
      i_last = l;
      i_locked = k;
      for (int n = 0; n < 99 && o_accept !== 1'b1; n++)
         tick();
      check(o_accept, 1'b1);
      tick();
      i_req = 1'b0;
      for (int n = 0; n < 99 && c == 2'h0 && o_rvalid !== 1'b1; n++)
         tick();
      if (c == 2'h0)
         check(o_rvalid, 1'b1);
      rd = o_rdata;
   endtask
   task automatic prefix(input logic [7:0] c);
      logic [22:0] exp [3];
      exp = '{{15'h5555, 8'haa}, {15'h2aaa, 8'h55}, {15'h5555, c}};
      for (int i = 0; i < 3; i++)
         check(wr_log[i][22:0], exp[i]);
   endtask
   task automatic write_page(input logic [18:0] b, input int cnt, input logic lk, input logic keep);
      int d0;
      int f;
      logic [18:0] a;
      logic [7:0] d;
      d0 = dones;
      f = lk ? 3 : 0;
      wr_log.delete();
      for (int i = 0; i < cnt; i++)
      begin
         a = {b[18:8], b[7:0] + 8'(i)};
         d = 8'($urandom);
         if (keep)
            ref_mem[a] = d;
         req(2'h1, a, d, i == cnt - 1, lk && i == 0);
      end
      wait_done(d0);
      check(wr_log.size(), cnt + f);
      for (int i = f + 1; i < wr_log.size(); i++)
         check(wr_log[i][26:16], wr_log[f][26:16]);
      if (lk)
         prefix(8'ha0);
   endtask
   task automatic lock_cmd(input logic [1:0] c, input logic [7:0] code);
      int d0;
      d0 = dones;
      wr_log.delete();
      req(c, 19'h0_0000, 8'h00, 1'b0, 1'b0);
      wait_done(d0);
      check(wr_log.size(), 3);
      prefix(code);
   endtask
   task automatic verify(input logic [18:0] b, input int cnt);
      logic [18:0] a;
      for (int i = 0; i < cnt; i++)
      begin
         a = {b[18:8], b[7:0] + 8'(i)};
         req(2'h0, a, 8'h00, 1'b0, 1'b0);
         check(rd, ref_mem.exists(a) ? ref_mem[a] : 8'hff);
      end
   endtask
   initial
   begin
      repeat (90000) @(posedge i_mclk);
      fails++;
      print_verdict();
   end
   initial
   begin
      logic [18:0] p;
      int n;
      int d0;
      void'($urandom(32'h0000_48bc));
      repeat (2) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         p = 19'($urandom);
         n = 1 + $urandom % 16;
         write_page(p, n, 1'b0, 1'b1);
         verify(p, n);
      end
      write_page(19'h1_2300, 256, 1'b0, 1'b1);
      verify(19'h1_2300, 256);
      write_page(19'h0_4500, 4, 1'b1, 1'b1);
      verify(19'h0_4500, 4);
      // Locked device still runs its timers, so the refused write ends by polling if the stored top bit matches the written one, else by timeout
      for (int k = 0; k < 2; k++)
      begin
         write_page(19'h0_4500, 2, 1'b0, 1'b0);
         verify(19'h0_4500, 2);
         lock_cmd(2'h3, 8'h80);
         write_page(19'h0_4600, 2, 1'b0, 1'b1);
         verify(19'h0_4600, 2);
         lock_cmd(2'h2, 8'ha0);
      end
      lock_cmd(2'h3, 8'h80);
      d0 = dones;
      ref_mem[19'h2_0010] = 8'h3c;
      req(2'h1, 19'h2_0010, 8'h3c, 1'b0, 1'b0);
      repeat (2500) tick();
      check(dones - d0, 1);
      verify(19'h2_0010, 1);
      wc = 32'h0000_1770;
      write_page(19'h3_0000, 1, 1'b0, 1'b1);
      check(o_timeout, 1'b1);
      repeat (6000) tick();
      wc = 32'h0000_012c;
      write_page(19'h3_0001, 1, 1'b0, 1'b1);
      check(o_timeout, 1'b0);
      verify(19'h3_0000, 2);
      print_verdict();
   end
endmodule
